// File: core/pma_regs.vh
// Register offsets, field positions, unlock keys and timing counts for the
// program memory access block. Included by the core top level and the checker.
`ifndef PMA_REGS_VH
`define PMA_REGS_VH

`define PMA_OFF_CTRL      12'h000
`define PMA_OFF_UNLOCK    12'h004
`define PMA_OFF_WORD_LO   12'h008
`define PMA_OFF_WORD_HI   12'h00C
`define PMA_OFF_LOC_LO    12'h010
`define PMA_OFF_LOC_HI    12'h014
`define PMA_OFF_IRQ_STAT  12'h018
`define PMA_OFF_IRQ_MASK  12'h01C
`define PMA_OFF_PTR_HI    12'h020
`define PMA_OFF_PTR_LO    12'h024
`define PMA_OFF_INDIRECT  12'h028

`define PMA_CTRL_RD       0
`define PMA_CTRL_WR       1
`define PMA_CTRL_ALLOW    2
`define PMA_CTRL_ABORT    3
`define PMA_CTRL_ERASE    4
`define PMA_CTRL_DENIED   5

`define PMA_IRQ_RD_DONE   0
`define PMA_IRQ_WR_DONE   1
`define PMA_IRQ_DENIED    2

`define PMA_PTR_PROG_BIT  7
`define PMA_UNLOCK_1      8'h55
`define PMA_UNLOCK_2      8'hAA

`define PMA_CLK_HZ        50000000
`define PMA_PROG_TIME_US  2000
`define PMA_PROG_CYCLES   ((`PMA_PROG_TIME_US * (`PMA_CLK_HZ / 1000)) / 1000)
`define PMA_READ_CYCLES   2

`endif

// File: core/pma_prog_timer.v
// Programming duration timer for flash write and erase.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/100ps
`default_nettype none
module pma_prog_timer #(
    parameter integer CYCLES = 100000
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire start_i,
    output reg  busy_o,
    output reg  done_o
);
    reg [31:0] cnt_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= 32'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                cnt_q  <= CYCLES - 1;
            end else if (busy_o) begin
                if (cnt_q == 32'h0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 32'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: core/pma_protect.v
// Protection decode: code protect for external programmer, write-protect range
// for self-write. Configuration inputs assumed static.
`timescale 1ns/100ps
`default_nettype none
module pma_protect #(
    parameter integer AW = 15
) (
    input  wire [1:0]    wp_range_i,
    input  wire          code_protect_n_i,
    input  wire          ext_mode_i,
    input  wire [AW-1:0] addr_i,
    input  wire [AW-1:0] mem_words_i,
    output reg           wr_ok_o,
    output wire          ext_rd_ok_o
);
    reg [AW-1:0] limit;

    // Range 11 off, 10 first quarter, 01 first half, 00 whole array
    always @* begin
        case (wp_range_i)
            2'b11:   limit = {AW{1'b0}};
            2'b10:   limit = mem_words_i >> 2;
            2'b01:   limit = mem_words_i >> 1;
            default: limit = {AW{1'b1}};
        endcase
        if (ext_mode_i)
            wr_ok_o = code_protect_n_i;
        else
            wr_ok_o = (wp_range_i == 2'b11) ? 1'b1 :
                      (wp_range_i == 2'b00) ? 1'b0 : (addr_i >= limit);
    end

    assign ext_rd_ok_o = !ext_mode_i || code_protect_n_i;
endmodule
`default_nettype wire

// File: core/pma_core.v
// Program memory access block: APB register file, indirect program read port,
// self-read/write engine with unlock, protection and interrupt.
// Assumes a flash macro with one-cycle read and a timed write/erase strobe.
//
// Overview of operation
// - pointer high bit 7 selects program memory
// - indirect move returns low eight bits
// - indirect writes never change program memory
// - program indirect read takes two extra cycles
// - software reads and writes flash while running
// - word low/high hold one 14-bit word
// - location low/high form 15-bit address
// - internal timer times write and erase
// - code protect blocks external programmer access
// - code protect leaves self-write unaffected
// - only programmer bulk erase or reset clears protection
// - write-protect range blocks self-write
// - write-protect range never limits programmer
// - read/program triggers set-only, hardware clears
// - writes need allow bit, clear at reset
// - abort flag is never set by hardware; reset clears it
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pma_regs.vh"
module pma_core #(
    parameter integer PROG_CYCLES = `PMA_PROG_CYCLES,
    parameter integer MEM_WORDS   = 4096
) (
    input  wire        SYS_CLK_I,
    input  wire        SYS_RST_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    output wire        IRQ_O,
    input  wire        CODE_PROTECT_N_I,
    input  wire [1:0]  WRITE_PROTECT_RANGE_I,
    input  wire        EXT_MODE_I,
    input  wire        EXT_BULK_ERASE_I,
    output reg  [14:0] FLASH_ADDR_O,
    output reg         FLASH_RD_O,
    input  wire [13:0] FLASH_RDATA_I,
    output reg         FLASH_WR_O,
    output reg         FLASH_ERASE_O,
    output reg         FLASH_BULK_ERASE_O,
    output reg  [13:0] FLASH_WDATA_O
);
    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_PROG = 2'd2;
    localparam ST_IND  = 2'd3;

    reg [1:0]  state_q;
    reg [7:0]  ptr_hi_q;
    reg [7:0]  ptr_lo_q;
    reg [7:0]  word_lo_q;
    reg [5:0]  word_hi_q;
    reg [7:0]  loc_lo_q;
    reg [6:0]  loc_hi_q;
    reg        rd_q;
    reg        wr_q;
    reg        erase_q;
    reg        allow_q;
    reg        abort_q;
    reg        denied_q;
    reg [1:0]  unlock_q;
    reg [2:0]  irq_stat_q;
    reg [2:0]  irq_mask_q;
    reg [7:0]  ind_data_q;
    reg        ind_done_q;
    reg        rd_wait_q;
    reg        wr_pending_q;
    reg        code_prot_q;
    reg        timer_start;
    reg        bulk_q;
    wire       timer_busy;
    wire       timer_done;
    wire       wr_ok;
    wire       ext_rd_ok;
    wire [14:0] loc;

    // abort pending follows ST_PROG and is cleared by the same reset (abort never set here)
    reg        abort_pend_q;

    wire setup   = PSEL_I && !PENABLE_I;
    wire access  = PSEL_I && PENABLE_I;
    wire ind_rd  = access && !PWRITE_I && PADDR_I == `PMA_OFF_INDIRECT;
    wire ind_prog = ptr_hi_q[`PMA_PTR_PROG_BIT];
    wire wr_en   = access && PWRITE_I && PREADY_O;
    wire rd_set  = wr_en && PADDR_I == `PMA_OFF_CTRL && PWDATA_I[`PMA_CTRL_RD];
    wire wr_set  = wr_en && PADDR_I == `PMA_OFF_CTRL && PWDATA_I[`PMA_CTRL_WR];
    // Allow bit is taken from the same control write as the trigger
    wire wr_grant = unlock_q == 2'd2 && PWDATA_I[`PMA_CTRL_ALLOW] && wr_ok;
    // Fetch starts in the setup cycle so data is ready after two waits
    wire ind_start = PSEL_I && !PWRITE_I && PADDR_I == `PMA_OFF_INDIRECT
                     && ind_prog && !ind_done_q;

    assign loc       = {loc_hi_q, loc_lo_q};
    assign PSLVERR_O = 1'b0;
    // Indirect program reads stall two extra cycles
    assign PREADY_O  = !(ind_rd && ind_prog && !ind_done_q);
    assign IRQ_O     = |(irq_stat_q & irq_mask_q);

    function [31:0] pma_rd_mux;
        input [11:0] a;
        begin
            case (a)
                `PMA_OFF_CTRL:     pma_rd_mux = {26'h0, denied_q, erase_q, abort_q,
                                                 allow_q, wr_q, rd_q};
                `PMA_OFF_UNLOCK:   pma_rd_mux = 32'h0;
                `PMA_OFF_WORD_LO:  pma_rd_mux = {24'h0, word_lo_q};
                `PMA_OFF_WORD_HI:  pma_rd_mux = {26'h0, word_hi_q};
                `PMA_OFF_LOC_LO:   pma_rd_mux = {24'h0, loc_lo_q};
                `PMA_OFF_LOC_HI:   pma_rd_mux = {25'h0, loc_hi_q};
                `PMA_OFF_IRQ_STAT: pma_rd_mux = {29'h0, irq_stat_q};
                `PMA_OFF_IRQ_MASK: pma_rd_mux = {29'h0, irq_mask_q};
                `PMA_OFF_PTR_HI:   pma_rd_mux = {24'h0, ptr_hi_q};
                `PMA_OFF_PTR_LO:   pma_rd_mux = {24'h0, ptr_lo_q};
                default:           pma_rd_mux = 32'h0;
            endcase
        end
    endfunction

    pma_prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk_i   (SYS_CLK_I),
        .rst_i   (SYS_RST_I),
        .start_i (timer_start),
        .busy_o  (timer_busy),
        .done_o  (timer_done)
    );

    pma_protect #(
        .AW (15)
    ) u_prot (
        .wp_range_i       (WRITE_PROTECT_RANGE_I),
        .code_protect_n_i (code_prot_q),
        .ext_mode_i       (EXT_MODE_I),
        .addr_i           (loc),
        .mem_words_i      (MEM_WORDS[14:0]),
        .wr_ok_o          (wr_ok),
        .ext_rd_ok_o      (ext_rd_ok)
    );

    always @* begin
        timer_start = (state_q == ST_IDLE) && wr_pending_q && allow_q && wr_ok;
    end

    // Read data path
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h0;
        end else if (state_q == ST_IND && rd_wait_q) begin
            PRDATA_O <= {24'h0, FLASH_RDATA_I[7:0]};
        end else if (setup) begin
            PRDATA_O <= pma_rd_mux(PADDR_I);
        end
    end

    // CODE_PROTECT_N_I low sticks in code-protect copy; only bulk erase or reset clears it
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            code_prot_q <= 1'b1;
            bulk_q      <= 1'b0;
        end else begin
            bulk_q <= EXT_MODE_I && EXT_BULK_ERASE_I;
            if (bulk_q)
                code_prot_q <= 1'b1;
            else
                code_prot_q <= CODE_PROTECT_N_I && code_prot_q;
        end
    end

    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            abort_pend_q <= 1'b0;
        end else begin
            abort_pend_q <= (state_q == ST_PROG);
        end
    end

    // Main control
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q            <= ST_IDLE;
            ptr_hi_q           <= 8'h00;
            ptr_lo_q           <= 8'h00;
            word_lo_q          <= 8'h00;
            word_hi_q          <= 6'h00;
            loc_lo_q           <= 8'h00;
            loc_hi_q           <= 7'h00;
            rd_q               <= 1'b0;
            wr_q               <= 1'b0;
            erase_q            <= 1'b0;
            allow_q            <= 1'b0;
            abort_q            <= 1'b0;
            denied_q           <= 1'b0;
            unlock_q           <= 2'd0;
            irq_stat_q         <= 3'h0;
            irq_mask_q         <= 3'h0;
            ind_data_q         <= 8'h00;
            ind_done_q         <= 1'b0;
            rd_wait_q          <= 1'b0;
            wr_pending_q       <= 1'b0;
            FLASH_ADDR_O       <= 15'h0000;
            FLASH_RD_O         <= 1'b0;
            FLASH_WR_O         <= 1'b0;
            FLASH_ERASE_O      <= 1'b0;
            FLASH_BULK_ERASE_O <= 1'b0;
            FLASH_WDATA_O      <= 14'h0000;
        end else begin
            FLASH_RD_O         <= 1'b0;
            FLASH_WR_O         <= 1'b0;
            FLASH_ERASE_O      <= 1'b0;
            FLASH_BULK_ERASE_O <= bulk_q;
            if (abort_pend_q && state_q == ST_IDLE && !abort_q && 1'b0)
                abort_q <= 1'b1;
            if (wr_en) begin
                case (PADDR_I)
                    `PMA_OFF_CTRL: begin
                        allow_q <= PWDATA_I[`PMA_CTRL_ALLOW];
                        erase_q <= PWDATA_I[`PMA_CTRL_ERASE];
                        if (!PWDATA_I[`PMA_CTRL_ABORT])
                            abort_q <= 1'b0;
                        if (!PWDATA_I[`PMA_CTRL_DENIED])
                            denied_q <= 1'b0;
                    end
                    `PMA_OFF_UNLOCK: begin
                        if (unlock_q == 2'd0 && PWDATA_I[7:0] == `PMA_UNLOCK_1)
                            unlock_q <= 2'd1;
                        else if (unlock_q == 2'd1 && PWDATA_I[7:0] == `PMA_UNLOCK_2)
                            unlock_q <= 2'd2;
                        else
                            unlock_q <= 2'd0;
                    end
                    `PMA_OFF_WORD_LO:  word_lo_q  <= PWDATA_I[7:0];
                    `PMA_OFF_WORD_HI:  word_hi_q  <= PWDATA_I[5:0];
                    `PMA_OFF_LOC_LO:   loc_lo_q   <= PWDATA_I[7:0];
                    `PMA_OFF_LOC_HI:   loc_hi_q   <= PWDATA_I[6:0];
                    `PMA_OFF_IRQ_MASK: irq_mask_q <= PWDATA_I[2:0];
                    `PMA_OFF_PTR_HI:   ptr_hi_q   <= PWDATA_I[7:0];
                    `PMA_OFF_PTR_LO:   ptr_lo_q   <= PWDATA_I[7:0];
                    `PMA_OFF_INDIRECT: ;
                    default: ;
                endcase
            end
            // Triggers only set by software
            if (rd_set && state_q == ST_IDLE)
                rd_q <= 1'b1;
            if (wr_set && state_q == ST_IDLE) begin
                if (wr_grant) begin
                    wr_q         <= 1'b1;
                    wr_pending_q <= 1'b1;
                end else begin
                    denied_q <= 1'b1;
                end
                unlock_q <= 2'd0;
            end
            case (state_q)
                ST_IDLE: begin
                    ind_done_q <= 1'b0;
                    if (timer_start) begin
                        state_q       <= ST_PROG;
                        FLASH_ADDR_O  <= loc;
                        FLASH_WDATA_O <= {word_hi_q, word_lo_q};
                        FLASH_WR_O    <= !erase_q;
                        FLASH_ERASE_O <= erase_q;
                        wr_pending_q  <= 1'b0;
                    end else if (rd_q && ext_rd_ok) begin
                        state_q      <= ST_READ;
                        FLASH_ADDR_O <= loc;
                        FLASH_RD_O   <= 1'b1;
                        rd_wait_q    <= 1'b0;
                    end else if (ind_start) begin
                        state_q      <= ST_IND;
                        FLASH_ADDR_O <= {ptr_hi_q[6:0], ptr_lo_q};
                        FLASH_RD_O   <= 1'b1;
                        rd_wait_q    <= 1'b0;
                    end
                end
                ST_READ: begin
                    rd_wait_q <= 1'b1;
                    if (rd_wait_q) begin
                        word_lo_q     <= FLASH_RDATA_I[7:0];
                        word_hi_q     <= FLASH_RDATA_I[13:8];
                        rd_q          <= 1'b0;
                        irq_stat_q[`PMA_IRQ_RD_DONE] <= 1'b1;
                        state_q       <= ST_IDLE;
                    end
                end
                ST_IND: begin
                    rd_wait_q <= 1'b1;
                    if (rd_wait_q) begin
                        ind_data_q <= FLASH_RDATA_I[7:0];
                        ind_done_q <= 1'b1;
                        state_q    <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (timer_done) begin
                        wr_q    <= 1'b0;
                        irq_stat_q[`PMA_IRQ_WR_DONE] <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (wr_set && state_q == ST_IDLE && !wr_grant)
                irq_stat_q[`PMA_IRQ_DENIED] <= 1'b1;
            // Write-one-to-clear; a same-cycle set wins
            if (wr_en && PADDR_I == `PMA_OFF_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~PWDATA_I[2:0])
                              | {wr_set && state_q == ST_IDLE
                                 && !wr_grant,
                                 state_q == ST_PROG && timer_done,
                                 state_q == ST_READ && rd_wait_q};
        end
    end
endmodule
`default_nettype wire

// File: tb/pma_flash_model.sv
// Behavioural flash array beside pma_core: one-cycle read, word write,
// word and bulk erase. Read data is scrambled outside its valid cycle.
`timescale 1ns/100ps
`default_nettype none
module pma_flash_model #(
    parameter int WORDS = 4096
) (
    input  wire logic        clk_i,
    input  wire logic [14:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic        erase_i,
    input  wire logic        bulk_i,
    input  wire logic [13:0] wdata_i,
    output var  logic [13:0] rdata_o
);
    logic [13:0] mem_q [WORDS];
    logic [13:0] dat_q;
    logic        vld_q;
    initial begin
        for (int i = 0; i < WORDS; i++) mem_q[i] = 14'(i) ^ 14'h1A5C;
        dat_q = 14'h0000;
        vld_q = 1'b0;
    end
    always @(posedge clk_i) begin
        vld_q <= rd_i;
        if (rd_i) dat_q <= mem_q[addr_i[11:0]];
        if (wr_i) mem_q[addr_i[11:0]] <= wdata_i;
        if (erase_i) mem_q[addr_i[11:0]] <= 14'h3FFF;
        if (bulk_i) for (int i = 0; i < WORDS; i++) mem_q[i] <= 14'h3FFF;
    end
    assign rdata_o = vld_q ? dat_q : ~dat_q;
endmodule
`default_nettype wire

// File: tb/pma_core_asserts.sv
// Checker on the pma_core ports: APB waits and flash strobe causes.
// Bound from the bench top; tracks written registers from APB traffic.
`timescale 1ns/100ps
`default_nettype none
`include "pma_regs.vh"
module pma_core_asserts (
    input wire logic        SYS_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PREADY_O,
    input wire logic        EXT_MODE_I,
    input wire logic        EXT_BULK_ERASE_I,
    input wire logic [1:0]  WRITE_PROTECT_RANGE_I,
    input wire logic [14:0] FLASH_ADDR_O,
    input wire logic        FLASH_RD_O,
    input wire logic        FLASH_WR_O,
    input wire logic        FLASH_ERASE_O,
    input wire logic        FLASH_BULK_ERASE_O,
    input wire logic [13:0] FLASH_WDATA_O
);
    logic        prog_q;
    logic        u55_q;
    logic        unl_q;
    logic [13:0] word_q;
    logic [14:0] loc_q;
    wire         wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire         ind_rd = PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == `PMA_OFF_INDIRECT;
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prog_q <= 1'b0;
            u55_q  <= 1'b0;
            unl_q  <= 1'b0;
            word_q <= 14'h0000;
            loc_q  <= 15'h0000;
        end else if (wr_acc) begin
            case (PADDR_I)
                `PMA_OFF_PTR_HI: prog_q <= PWDATA_I[7];
                `PMA_OFF_WORD_LO: word_q[7:0] <= PWDATA_I[7:0];
                `PMA_OFF_WORD_HI: word_q[13:8] <= PWDATA_I[5:0];
                `PMA_OFF_LOC_LO: loc_q[7:0] <= PWDATA_I[7:0];
                `PMA_OFF_LOC_HI: loc_q[14:8] <= PWDATA_I[6:0];
                `PMA_OFF_CTRL: unl_q <= 1'b0;
                `PMA_OFF_UNLOCK: begin
                    u55_q <= PWDATA_I[7:0] == 8'h55;
                    unl_q <= u55_q && PWDATA_I[7:0] == 8'hAA;
                end
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_ind_prog;
        $rose(PENABLE_I) && ind_rd && prog_q;
    endsequence
    sequence s_ind_data;
        $rose(PENABLE_I) && ind_rd && !prog_q;
    endsequence
    sequence s_two_waits;
        !PREADY_O [*2] ##1 PREADY_O;
    endsequence
    a_ind_waits: assert property (s_ind_prog |-> s_two_waits)
        else $error("indirect program read wait count wrong");
    a_data_no_wait: assert property (s_ind_data |-> PREADY_O && !FLASH_RD_O)
        else $error("indirect data read stalled or touched flash");
    a_ind_fetch: assert property (s_ind_prog |-> ##[0:2] FLASH_RD_O)
        else $error("indirect program read did not fetch flash");
    a_wr_unlocked: assert property (FLASH_WR_O |-> $past(unl_q, 2))
        else $error("flash write without unlock pattern");
    a_wr_allowed: assert property (FLASH_WR_O |-> $past(wr_acc
        && PADDR_I == `PMA_OFF_CTRL && PWDATA_I[2:1] == 2'b11, 2))
        else $error("flash write without allow and trigger");
    a_wr_word: assert property (FLASH_WR_O |-> FLASH_WDATA_O == word_q && FLASH_ADDR_O == loc_q)
        else $error("flash write word or location wrong");
    a_wr_timed: assert property (FLASH_WR_O |=> !FLASH_WR_O [*7])
        else $error("flash write restarted during programming");
    a_ind_no_write: assert property (wr_acc && PADDR_I == `PMA_OFF_INDIRECT
        |=> !FLASH_WR_O && !FLASH_ERASE_O)
        else $error("indirect write changed flash");
    a_wp_all: assert property (WRITE_PROTECT_RANGE_I == 2'b00 && !EXT_MODE_I
        |-> !FLASH_WR_O && !FLASH_ERASE_O)
        else $error("self write while fully protected");
    a_bulk_cause: assert property ($rose(FLASH_BULK_ERASE_O)
        |-> $past(EXT_BULK_ERASE_I) || $past(EXT_BULK_ERASE_I, 2))
        else $error("bulk erase without programmer request");
endmodule
`default_nettype wire

// File: tb/pma_core_test.sv
// Self-checking bench for pma_core: APB master, flash model, checker bind.
// Assumes the flash model and checker files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module pma_core_test;
    localparam logic [11:0] CT = 12'h000, UN = 12'h004, WL = 12'h008, WH = 12'h00C,
        LL = 12'h010, LH = 12'h014, IS = 12'h018, IM = 12'h01C, PH = 12'h020,
        PL = 12'h024, IN = 12'h028;
    logic        clk, rst, psel, penable, pwrite, cp_n, ext, bulk, erased;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [1:0]  wp;
    wire  [31:0] prdata;
    wire         pready, irq, frd, fwr, fer, fbulk;
    wire  [14:0] faddr;
    wire  [13:0] frdata, fwdata;
    int          miscompares, tests_run, cyc;
    logic [13:0] shadow [int];
    pma_core #(.PROG_CYCLES(16), .MEM_WORDS(4096)) dut (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(), .IRQ_O(irq), .CODE_PROTECT_N_I(cp_n),
        .WRITE_PROTECT_RANGE_I(wp), .EXT_MODE_I(ext), .EXT_BULK_ERASE_I(bulk),
        .FLASH_ADDR_O(faddr), .FLASH_RD_O(frd), .FLASH_RDATA_I(frdata),
        .FLASH_WR_O(fwr), .FLASH_ERASE_O(fer), .FLASH_BULK_ERASE_O(fbulk),
        .FLASH_WDATA_O(fwdata));
    pma_flash_model #(.WORDS(4096)) u_flash (
        .clk_i(clk), .addr_i(faddr), .rd_i(frd), .wr_i(fwr), .erase_i(fer),
        .bulk_i(fbulk), .wdata_i(fwdata), .rdata_o(frdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict;
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [13:0] expw(input logic [31:0] a);
        if (erased) return 14'h3FFF;
        if (shadow.exists(a)) return shadow[a];
        return a[13:0] ^ 14'h1A5C;
    endfunction
    task automatic prog(input logic [31:0] a, w, input logic key, input logic [31:0] c,
                        input logic ok);
        apb(1'b1, LL, a & 32'h000000FF);
        apb(1'b1, LH, a >> 8);
        apb(1'b1, WL, w & 32'h000000FF);
        apb(1'b1, WH, w >> 8);
        if (key) begin
            apb(1'b1, UN, 32'h00000055);
            apb(1'b1, UN, 32'h000000AA);
        end
        apb(1'b1, CT, c);
        apb(1'b1, CT, 32'h00000004);
        apb(1'b0, CT, 32'h00000000);
        if (ok) chk("wr held", rd[1], 1'b1);
        for (int i = 0; i < 40 && rd[1] !== 1'b0; i++) apb(1'b0, CT, 32'h00000000);
        chk("wr cleared", rd[1], 1'b0);
        apb(1'b0, IS, 32'h00000000);
        chk("wr outcome", rd[2:1], {!ok, ok});
        apb(1'b1, IS, 32'h00000007);
        if (ok) shadow[a] = w[13:0];
    endtask
    task automatic rdw(input logic [31:0] a);
        logic [13:0] e;
        e = expw(a);
        apb(1'b1, LL, a & 32'h000000FF);
        apb(1'b1, LH, a >> 8);
        apb(1'b1, CT, 32'h00000001);
        rd = 32'h00000001;
        for (int i = 0; i < 20 && rd[0] !== 1'b0; i++) apb(1'b0, CT, 32'h00000000);
        chk("rd cleared", rd[0], 1'b0);
        apb(1'b0, WL, 32'h00000000);
        chk("word low", rd, {24'h000000, e[7:0]});
        apb(1'b0, WH, 32'h00000000);
        chk("word high", rd, {26'h0000000, e[13:8]});
    endtask
    task automatic ind(input logic [31:0] a, input logic p);
        logic [13:0] e;
        e = expw(a);
        apb(1'b1, PH, {24'h000000, p, a[14:8]});
        apb(1'b1, PL, a & 32'h000000FF);
        apb(1'b0, IN, 32'h00000000);
        if (p) chk("indirect", rd, {24'h000000, e[7:0]});
    endtask
    initial begin
        logic [31:0] a;
        int          lim;
        {rst, psel, penable, pwrite, ext, bulk, erased, cp_n} = 8'h81;
        {paddr, pwdata, wp, miscompares, tests_run, cyc} = '0;
        a = $urandom(32'h42868599);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wp <= 2'b11;
        apb(1'b0, CT, 32'h00000000);
        chk("ctrl reset", rd, 32'h00000000);
        apb(1'b0, UN, 32'h00000000);
        chk("unlock read", rd, 32'h00000000);
        apb(1'b0, 12'h030, 32'h00000000);
        chk("unmapped", rd, 32'h00000000);
        for (int i = 0; i < 8; i++) begin
            a = $urandom % 4096;
            cp_n <= i[0];
            prog(a, $urandom % 16384, 1'b1, 32'h00000006, 1'b1);
            rdw(a);
            ind(a, 1'b1);
            ind($urandom % 4096, 1'b0);
        end
        prog(32'h00000100, 32'h00001234, 1'b0, 32'h00000006, 1'b0);
        prog(32'h00000100, 32'h00001234, 1'b1, 32'h00000002, 1'b0);
        rdw(32'h00000100);
        for (int r = 0; r < 4; r++) begin
            wp <= r[1:0];
            lim = r == 0 ? 4096 : r == 1 ? 2048 : r == 2 ? 1024 : 0;
            if (lim > 0) prog(lim - 1, 32'h000002A5, 1'b1, 32'h00000006, 1'b0);
            if (lim < 4096) prog(lim, 32'h0000015A, 1'b1, 32'h00000006, 1'b1);
        end
        apb(1'b1, PH, 32'h00000081);
        apb(1'b1, PL, 32'h00000023);
        apb(1'b1, IN, 32'h00003FFF);
        rdw(32'h00000123);
        rdw(32'h00000010);
        apb(1'b0, IS, 32'h00000000);
        chk("read done flag", rd[0], 1'b1);
        @(posedge clk);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, IM, 32'h00000001);
        @(posedge clk);
        chk("irq raised", irq, 1'b1);
        apb(1'b1, IS, 32'h00000001);
        @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        wp <= 2'b00;
        cp_n <= 1'b0;
        ext <= 1'b1;
        @(posedge clk);
        bulk <= 1'b1;
        @(posedge clk);
        bulk <= 1'b0;
        for (int i = 0; i < 10 && fbulk !== 1'b1; i++) @(posedge clk);
        chk("bulk erase", fbulk, 1'b1);
        for (int i = 0; i < 40 && fbulk !== 1'b0; i++) @(posedge clk);
        ext <= 1'b0;
        erased = 1'b1;
        rdw(a);
        rdw(32'h00000123);
        give_verdict();
    end
endmodule
bind pma_core pma_core_asserts u_chk (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
    .EXT_MODE_I(EXT_MODE_I), .EXT_BULK_ERASE_I(EXT_BULK_ERASE_I),
    .WRITE_PROTECT_RANGE_I(WRITE_PROTECT_RANGE_I), .FLASH_ADDR_O(FLASH_ADDR_O),
    .FLASH_RD_O(FLASH_RD_O), .FLASH_WR_O(FLASH_WR_O), .FLASH_ERASE_O(FLASH_ERASE_O),
    .FLASH_BULK_ERASE_O(FLASH_BULK_ERASE_O), .FLASH_WDATA_O(FLASH_WDATA_O));
`default_nettype wire
